// ===== pkg/cspd_pkg.sv
package cspd_pkg;

    // Processor clock, 10 MHz
    localparam int CLK_PERIOD_NS = 100;

    // Offsets inside the peripheral register block
    localparam logic [7:0] OFS_UPPER_SELECT_CONFIG   = 8'h00a0;
    localparam logic [7:0] OFS_LOW_SELECT_CONFIG     = 8'h00a2;
    localparam logic [7:0] OFS_RESET_CONFIG_LATCH    = 8'h00f6;
    localparam logic [7:0] OFS_PERIPH_BLOCK_RELOC    = 8'h00fe;

    // Values after reset
    localparam logic [15:0] RST_UPPER_SELECT_CONFIG  = 16'hf03b;
    localparam logic [15:0] RST_LOW_SELECT_CONFIG    = 16'h0000;
    localparam logic [15:0] RST_PERIPH_BLOCK_RELOC   = 16'h20ff;
    localparam logic [19:0] BOOT_FETCH_ADDR          = 20'hf_fff0;

    // Field positions
    localparam int SEL_BOUND_MSB      = 14;
    localparam int SEL_BOUND_LSB      = 12;
    localparam int SEL_ADDR_DRIVE_OFF = 7;
    localparam int SEL_READY_IGNORE   = 2;
    localparam int SEL_WAIT_MSB       = 1;
    localparam int RELOC_INTC_SLAVE   = 14;
    localparam int RELOC_BLOCK_SPACE  = 12;
    localparam int RELOC_BASE_MSB     = 11;

    // Writable bits of each register; the rest read as zero after a write, though the upper and relocation reset values set some
    localparam logic [15:0] MASK_SELECT_CONFIG       = 16'h7087;
    localparam logic [15:0] MASK_PERIPH_BLOCK_RELOC  = 16'h5fff;

    // Periph select indices; the fifth one has no pin
    localparam int NUM_PERIPH_SELECTS          = 7;
    localparam int INTERNAL_FIFTH_PERIPH_SELECT = 4;
    localparam int SIXTH_PERIPH_SELECT          = 5;
    localparam int SEVENTH_PERIPH_SELECT        = 6;

    // Programmable I/O pins
    localparam int NUM_PIO                = 32;
    localparam int PIO_DATA_DIRECTION_PIN = 4;
    localparam int PIO_DATA_ENABLE_PIN    = 5;
    localparam int PIO_SYNC_READY_PIN     = 6;
    localparam int PIO_ADDR17_PIN         = 7;
    localparam int PIO_ADDR18_PIN         = 8;
    localparam int PIO_ADDR19_PIN         = 9;
    localparam int PIO_UPPER_BYTE_PIN     = 26;
    localparam int PIO_STATUS_SIX_CLOCK_DIVIDE_PIN = 29;
    // 1 = normal function; pins not named above default to normal too
    localparam logic [31:0] RST_PIO_NORMAL = 32'hffff_ffff;

    typedef struct packed {
        logic        valid;
        logic        is_mem;
        logic        write;
        logic [19:0] addr;
        logic [15:0] wdata;
    } cspd_access_type;

    typedef struct packed {
        logic       upper_sel_n;
        logic       low_sel_n;
        logic       pcb_sel;
        logic       ext_ready_req;
        logic [3:0] wait_states;
        logic       addr_drive_en;
        logic       overlap_conflict;
    } cspd_strobe_type;

endpackage

// ===== src/cspd_chip_select.sv
`timescale 1ns/1ns
// Overview of operation
// R1 - Peripheral block select: zero waits, external ready never required.
// R2 - Software keeps overlapping selects identical in ready mode and wait count.
// R3 - Addr-drive-off on low/upper select suppresses address whenever that select hits.
// R4 - Mid and periph select ready/wait settings apply even when pins are I/O.
// R5 - Pinless fifth periph select keeps ready/wait logic and overlap checking.
// R6 - Sixth/seventh periph selects as address bits lose ready/wait logic.
// R7 - First fetch after reset comes from the fixed boot address.
// R8 - Upper select active at reset: top 64K, ready required, three waits.
// R9 - Upper select lower bound programmable, 64K to 512K, top fixed.
// R10 - Top address pins, direction, enable, sync ready default to normal.
// R11 - Every reset returns all 32 I/O pins to default configuration.
// R12 - Strap low forces status-six and upper-byte pins to normal function.
// R13 - Peripheral registers decode as one 256-byte block in I/O or memory.
// R14 - Software uses aligned word reads; unaligned access is indeterminate.
// R15 - Relocation register resets to 20ff hex.
// R16 - Relocation bit 14 selects interrupt controller slave mode.
// R17 - Relocation bit 12 maps block to memory space, else I/O.
// R18 - Relocation bits 11..0 give base 19..8; 19..16 ignored in memory.
// R19 - Strap pins captured at reset release, held read-only until next reset.
// R20 - Strap low at reset: address always driven, drive-off bits ignored.
// R21 - Addr-drive-off is bit 7 of low select config, cleared by reset.
// R22 - Block select asserts on space match and base address match.
module cspd_chip_select
    import cspd_pkg::*;
(
    input  wire logic                          sys_clk_in,
    input  wire logic                          srst_in,
    input  wire cspd_access_type               access_in,
    input  wire logic [15:0]                   strap_pins_in,
    input  wire logic                          addr_enable_strap_n_in,
    input  wire logic                          mid_hit_in,
    input  wire logic [2:0]                    mid_cfg_in,
    input  wire logic [NUM_PERIPH_SELECTS-1:0] periph_hit_in,
    input  wire logic [3:0]                    periph_low_cfg_in,
    input  wire logic [3:0]                    periph_high_cfg_in,
    input  wire logic                          periph_addr_mode_in,
    input  wire logic                          pio_write_in,
    input  wire logic [NUM_PIO-1:0]            pio_normal_in,
    output cspd_strobe_type                    strobe_out,
    output logic [15:0]                        rdata_out,
    output logic                               rdata_valid_out,
    output logic [19:0]                        fetch_addr_out,
    output logic                               intc_slave_select_out,
    output logic                               block_space_select_out,
    output logic [NUM_PIO-1:0]                 pio_normal_out
);

    // Two-bit wait code of the low and upper selects, 0..3
    function automatic logic [3:0] ws_short(input logic [1:0] code);
        ws_short = {2'b00, code};
    endfunction

    // Three-bit wait code of the periph selects: 0,1,2,3,5,7,9,15
    function automatic logic [3:0] ws_long(input logic [3:0] cfg);
        logic [2:0] code;
        code = {cfg[3], cfg[1:0]};
        case (code)
            3'h4:    ws_long = 4'h5;
            3'h5:    ws_long = 4'h7;
            3'h6:    ws_long = 4'h9;
            3'h7:    ws_long = 4'hf;
            default: ws_long = {2'b00, code[1:0]};
        endcase
    endfunction

    // Whole-word offset; byte lane bit not decoded
    function automatic logic [7:0] word_ofs(input logic [7:0] ofs);
        word_ofs = {ofs[7:1], 1'b0};
    endfunction

    // Bus override keeps status-six and upper-byte pins normal
    function automatic logic [NUM_PIO-1:0] override_pins(input logic [NUM_PIO-1:0] v);
        override_pins = v;
        override_pins[PIO_STATUS_SIX_CLOCK_DIVIDE_PIN] = 1'b1;
        override_pins[PIO_UPPER_BYTE_PIN]              = 1'b1;
    endfunction

    logic [15:0]           upper_select_config;
    logic [15:0]           low_select_config;
    logic                  low_select_enabled;
    logic [15:0]           periph_block_relocation;
    logic [15:0]           reset_config_latch;
    logic                  strap_bus_override;
    logic                  capture_pending;

    logic                  upper_hit;
    logic                  low_hit;
    logic                  pcb_hit;
    logic [7:0]            pcb_offset;
    logic                  reg_write;
    logic [NUM_PERIPH_SELECTS-1:0] periph_live;
    logic                  next_ready_req;
    logic [3:0]            next_wait;
    logic                  next_conflict;
    logic                  next_addr_drive;
    logic [15:0]           next_rdata;

    // R9 upper window bound
    // Bound bits all ones give 64K; each cleared bit doubles the window downwards
    assign upper_hit = access_in.valid && access_in.is_mem && access_in.addr[19]
        && ((access_in.addr[18:16] & upper_select_config[SEL_BOUND_MSB:SEL_BOUND_LSB])
            == upper_select_config[SEL_BOUND_MSB:SEL_BOUND_LSB]);

    // Low select is dead until software first writes its config
    assign low_hit = access_in.valid && access_in.is_mem && low_select_enabled
        && !access_in.addr[19]
        && ((access_in.addr[18:16] & ~low_select_config[SEL_BOUND_MSB:SEL_BOUND_LSB])
            == 3'b000);

    // R13 one 256-byte block
    // R17 memory or I/O space
    // R18 base bits, upper nibble ignored in memory
    // R22 block select decode
    always_comb begin
        pcb_hit = 1'b0;
        if (access_in.valid) begin
            if (periph_block_relocation[RELOC_BLOCK_SPACE]) begin
                pcb_hit = access_in.is_mem
                    && (access_in.addr[15:8] == periph_block_relocation[7:0]);
            end else begin
                pcb_hit = !access_in.is_mem
                    && (access_in.addr[19:8] == periph_block_relocation[RELOC_BASE_MSB:0]);
            end
        end
    end

    // Latch has no write path, so writes to it are dropped
    assign pcb_offset = access_in.addr[7:0];
    assign reg_write  = pcb_hit && access_in.write;

    // R4 config applies whatever the pin function
    // R5 fifth select stays live without a pin
    // R6 address-bit mode silences sixth and seventh
    always_comb begin
        periph_live = periph_hit_in;
        if (periph_addr_mode_in) begin
            periph_live[SIXTH_PERIPH_SELECT]   = 1'b0;
            periph_live[SEVENTH_PERIPH_SELECT] = 1'b0;
        end
    end

    // R2 overlap is software's duty; hardware merges and flags
    // Merge takes the strictest setting so a mismatch stalls rather than corrupts
    always_comb begin
        logic       seen;
        logic       ref_rdy;
        logic [3:0] ref_ws;
        logic       rdy;
        logic [3:0] ws;
        logic       hit;
        seen           = 1'b0;
        ref_rdy        = 1'b0;
        ref_ws         = 4'h0;
        rdy            = 1'b0;
        ws             = 4'h0;
        hit            = 1'b0;
        next_ready_req = 1'b0;
        next_wait      = 4'h0;
        next_conflict  = 1'b0;
        for (int i = 0; i < NUM_PERIPH_SELECTS + 4; i++) begin
            hit = 1'b0;
            rdy = 1'b0;
            ws  = 4'h0;
            if (i < NUM_PERIPH_SELECTS) begin
                hit = periph_live[i];
                if (i < INTERNAL_FIFTH_PERIPH_SELECT) begin
                    rdy = !periph_low_cfg_in[SEL_READY_IGNORE];
                    ws  = ws_long(periph_low_cfg_in);
                end else begin
                    rdy = !periph_high_cfg_in[SEL_READY_IGNORE];
                    ws  = ws_long(periph_high_cfg_in);
                end
            end else if (i == NUM_PERIPH_SELECTS) begin
                hit = mid_hit_in;
                rdy = !mid_cfg_in[SEL_READY_IGNORE];
                ws  = ws_short(mid_cfg_in[SEL_WAIT_MSB:0]);
            end else if (i == NUM_PERIPH_SELECTS + 1) begin
                // R8 upper select ready and waits
                hit = upper_hit;
                rdy = !upper_select_config[SEL_READY_IGNORE];
                ws  = ws_short(upper_select_config[SEL_WAIT_MSB:0]);
            end else if (i == NUM_PERIPH_SELECTS + 2) begin
                hit = low_hit;
                rdy = !low_select_config[SEL_READY_IGNORE];
                ws  = ws_short(low_select_config[SEL_WAIT_MSB:0]);
            end else begin
                // R1 internal block: no waits, no ready
                hit = pcb_hit;
                rdy = 1'b0;
                ws  = 4'h0;
            end
            if (hit) begin
                if (seen && ((rdy != ref_rdy) || (ws != ref_ws))) begin
                    next_conflict = 1'b1;
                end
                seen    = 1'b1;
                ref_rdy = rdy;
                ref_ws  = ws;
                next_ready_req = next_ready_req | rdy;
                if (ws > next_wait) begin
                    next_wait = ws;
                end
            end
        end
    end

    // R3 drive-off wins for any access its select hits
    // R20 strap override keeps the address driven
    always_comb begin
        next_addr_drive = 1'b1;
        if (!strap_bus_override) begin
            if ((upper_hit && upper_select_config[SEL_ADDR_DRIVE_OFF])
                || (low_hit && low_select_config[SEL_ADDR_DRIVE_OFF])) begin
                next_addr_drive = 1'b0;
            end
        end
    end

    // R14 word-aligned reads only; low address bit is not decoded
    always_comb begin
        case (word_ofs(pcb_offset))
            OFS_UPPER_SELECT_CONFIG: next_rdata = upper_select_config;
            OFS_LOW_SELECT_CONFIG:   next_rdata = low_select_config;
            OFS_RESET_CONFIG_LATCH:  next_rdata = reset_config_latch;
            OFS_PERIPH_BLOCK_RELOC:  next_rdata = periph_block_relocation;
            default:                 next_rdata = 16'h0000;
        endcase
    end

    // R8 upper select reset defaults
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            upper_select_config <= RST_UPPER_SELECT_CONFIG;
        end else if (reg_write && (word_ofs(pcb_offset) == OFS_UPPER_SELECT_CONFIG)) begin
            upper_select_config <= access_in.wdata & MASK_SELECT_CONFIG;
        end
    end

    // R21 drive-off bit cleared by reset
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            low_select_config  <= RST_LOW_SELECT_CONFIG;
            low_select_enabled <= 1'b0;
        end else if (reg_write && (word_ofs(pcb_offset) == OFS_LOW_SELECT_CONFIG)) begin
            low_select_config  <= access_in.wdata & MASK_SELECT_CONFIG;
            low_select_enabled <= 1'b1;
        end
    end

    // R15 relocation reset value
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            periph_block_relocation <= RST_PERIPH_BLOCK_RELOC;
        end else if (reg_write && (word_ofs(pcb_offset) == OFS_PERIPH_BLOCK_RELOC)) begin
            periph_block_relocation <= access_in.wdata & MASK_PERIPH_BLOCK_RELOC;
        end
    end

    // R19 capture straps on release, hold until next reset
    // Sampled one edge after release, when the pins are known stable
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            capture_pending    <= 1'b1;
            reset_config_latch <= 16'h0000;
            strap_bus_override <= 1'b0;
        end else if (capture_pending) begin
            capture_pending    <= 1'b0;
            reset_config_latch <= strap_pins_in;
            strap_bus_override <= !addr_enable_strap_n_in;
        end
    end

    // R10 normal-function defaults
    // R11 all I/O pins back to default
    // R12 strap low forces status-six and upper-byte pins
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            pio_normal_out <= RST_PIO_NORMAL;
        end else if (capture_pending) begin
            if (!addr_enable_strap_n_in) begin
                pio_normal_out <= override_pins(pio_normal_out);
            end
        end else if (pio_write_in) begin
            if (strap_bus_override) begin
                pio_normal_out <= override_pins(pio_normal_in);
            end else begin
                pio_normal_out <= pio_normal_in;
            end
        end
    end

    // Strobe outputs lag the access by one edge
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            strobe_out.upper_sel_n      <= 1'b1;
            strobe_out.low_sel_n        <= 1'b1;
            strobe_out.pcb_sel          <= 1'b0;
            strobe_out.ext_ready_req    <= 1'b0;
            strobe_out.wait_states      <= 4'h0;
            strobe_out.addr_drive_en    <= 1'b1;
            strobe_out.overlap_conflict <= 1'b0;
        end else begin
            strobe_out.upper_sel_n      <= !upper_hit;
            strobe_out.low_sel_n        <= !low_hit;
            // R1 block select
            strobe_out.pcb_sel          <= pcb_hit;
            strobe_out.ext_ready_req    <= next_ready_req;
            strobe_out.wait_states      <= next_wait;
            strobe_out.addr_drive_en    <= next_addr_drive;
            strobe_out.overlap_conflict <= next_conflict;
        end
    end

    // Read data holds between reads; only the valid pulse marks new data
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rdata_out       <= 16'h0000;
            rdata_valid_out <= 1'b0;
        end else begin
            rdata_valid_out <= pcb_hit && !access_in.write;
            if (pcb_hit && !access_in.write) begin
                rdata_out <= next_rdata;
            end
        end
    end

    // R7 boot fetch address
    // R16 interrupt controller mode
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            fetch_addr_out         <= BOOT_FETCH_ADDR;
            intc_slave_select_out  <= 1'b0;
            block_space_select_out <= 1'b0;
        end else begin
            fetch_addr_out         <= BOOT_FETCH_ADDR;
            intc_slave_select_out  <= periph_block_relocation[RELOC_INTC_SLAVE];
            block_space_select_out <= periph_block_relocation[RELOC_BLOCK_SPACE];
        end
    end

endmodule // cspd_chip_select

// ===== verif/cspd_ext_decode.sv
`timescale 1ns/1ns
module cspd_ext_decode
    import cspd_pkg::*;
(
    input  wire cspd_access_type              access_in,
    output logic                              mid_hit_out,
    output logic [NUM_PERIPH_SELECTS-1:0]     periph_hit_out
);
    // Overlaps are allowed here on purpose; the bench picks the configs
    always_comb begin
        mid_hit_out = access_in.valid && access_in.is_mem && access_in.addr[19:16] == 4'h8;
        for (int i = 0; i < NUM_PERIPH_SELECTS; i++) begin
            periph_hit_out[i] = access_in.valid && !access_in.is_mem
                && access_in.addr[19:12] == 8'h01 && access_in.addr[i + 4];
        end
    end
endmodule // cspd_ext_decode

// ===== verif/cspd_chk.sv
`timescale 1ns/1ns
module cspd_chk
    import cspd_pkg::*;
(
    input wire logic                          sys_clk_in,
    input wire logic                          srst_in,
    input wire cspd_access_type               access_in,
    input wire logic                          mid_hit_in,
    input wire logic [NUM_PERIPH_SELECTS-1:0] periph_hit_in,
    input wire logic                          pio_write_in,
    input wire cspd_strobe_type               strobe_out,
    input wire logic [15:0]                   rdata_out,
    input wire logic                          rdata_valid_out,
    input wire logic [19:0]                   fetch_addr_out,
    input wire logic                          intc_slave_select_out,
    input wire logic                          block_space_select_out,
    input wire logic [NUM_PIO-1:0]            pio_normal_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    property p_fetch;
        fetch_addr_out == BOOT_FETCH_ADDR;
    endproperty
    property p_rdv;
        rdata_valid_out |-> $past(access_in.valid && !access_in.write) && !$past(srst_in);
    endproperty
    property p_rdhold;
        !rdata_valid_out && !$past(srst_in) |-> $stable(rdata_out);
    endproperty
    property p_boot;
        !$past(srst_in) && $past(access_in.valid && access_in.is_mem
            && access_in.addr[19:16] == 4'hf) |-> !strobe_out.upper_sel_n;
    endproperty
    property p_umiss;
        $past(access_in.valid && !access_in.addr[19]) |-> strobe_out.upper_sel_n;
    endproperty
    property p_pcb;
        strobe_out.pcb_sel && strobe_out.upper_sel_n && strobe_out.low_sel_n
            && $past(periph_hit_in == '0 && !mid_hit_in)
            |-> strobe_out.wait_states == 4'h0 && !strobe_out.ext_ready_req;
    endproperty
    property p_idle;
        $past(!access_in.valid && !mid_hit_in && periph_hit_in == '0)
            |-> strobe_out.upper_sel_n && !strobe_out.pcb_sel && !strobe_out.overlap_conflict;
    endproperty
    property p_pio_rst;
        $past(srst_in) |-> pio_normal_out == RST_PIO_NORMAL
            && !intc_slave_select_out && !block_space_select_out;
    endproperty
    property p_pio_hold;
        !$past(pio_write_in) && !$past(srst_in) |-> $stable(pio_normal_out);
    endproperty
    a_fetch: assert property (p_fetch) else $error("boot address wrong");
    a_rdv: assert property (p_rdv) else $error("read answer without read");
    a_rdhold: assert property (p_rdhold) else $error("read data moved");
    a_boot: assert property (p_boot) else $error("top 64K missed upper select");
    a_umiss: assert property (p_umiss) else $error("upper select below 512K");
    a_pcb: assert property (p_pcb) else $error("block select not zero wait");
    a_idle: assert property (p_idle) else $error("select without access");
    a_pio_rst: assert property (p_pio_rst) else $error("reset defaults wrong");
    a_pio_hold: assert property (p_pio_hold) else $error("pin function moved");
    c_boot: cover property (!strobe_out.upper_sel_n && strobe_out.wait_states == 4'h3);
    c_pcb: cover property (strobe_out.pcb_sel);
    c_conf: cover property (strobe_out.overlap_conflict);
endmodule // cspd_chk
bind cspd_chip_select cspd_chk cspd_chk_i (.sys_clk_in, .srst_in, .access_in, .mid_hit_in,
    .periph_hit_in, .pio_write_in, .strobe_out, .rdata_out, .rdata_valid_out, .fetch_addr_out,
    .intc_slave_select_out, .block_space_select_out, .pio_normal_out);

// ===== verif/testbench.sv
`timescale 1ns/1ns
module testbench;
    import cspd_pkg::*;
    logic                          sys_clk_in;
    logic                          srst_in;
    cspd_access_type               access_in;
    logic [15:0]                   strap_pins_in;
    logic                          addr_enable_strap_n_in;
    logic                          mid_hit_in;
    logic [2:0]                    mid_cfg_in;
    logic [NUM_PERIPH_SELECTS-1:0] periph_hit_in;
    logic [3:0]                    periph_low_cfg_in;
    logic [3:0]                    periph_high_cfg_in;
    logic                          periph_addr_mode_in;
    logic                          pio_write_in;
    logic [NUM_PIO-1:0]            pio_normal_in;
    cspd_strobe_type               strobe_out;
    logic [15:0]                   rdata_out;
    logic                          rdata_valid_out;
    logic [19:0]                   fetch_addr_out;
    logic                          intc_slave_select_out;
    logic                          block_space_select_out;
    logic [NUM_PIO-1:0]            pio_normal_out;
    logic [15:0]                   exp_q[$];
    logic [15:0]                   base;
    int                            n_mismatch;
    int                            n_tests;
    logic [3:0]                    wtab [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hf};

    cspd_chip_select cspd_chip_select_i (.sys_clk_in, .srst_in, .access_in, .strap_pins_in,
        .addr_enable_strap_n_in, .mid_hit_in, .mid_cfg_in, .periph_hit_in, .periph_low_cfg_in,
        .periph_high_cfg_in, .periph_addr_mode_in, .pio_write_in, .pio_normal_in, .strobe_out,
        .rdata_out, .rdata_valid_out, .fetch_addr_out, .intc_slave_select_out,
        .block_space_select_out, .pio_normal_out);
    cspd_ext_decode cspd_ext_decode_i (.access_in, .mid_hit_out(mid_hit_in),
        .periph_hit_out(periph_hit_in));

    initial begin
        sys_clk_in = 1'b0;
        forever #(CLK_PERIOD_NS / 2) sys_clk_in = ~sys_clk_in;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Idle cycle after the access, so valid is never driven twice in one step
    task automatic acc(input logic m, w, input logic [19:0] a, input logic [15:0] d);
        @(negedge sys_clk_in);
        access_in = '{1'b1, m, w, a, d};
        @(negedge sys_clk_in);
        access_in.valid = 1'b0;
    endtask

    task automatic rd(input logic m, input logic [19:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        acc(m, 1'b0, a, 16'h0000);
    endtask

    task automatic st(input logic u, p, r, input logic [3:0] w, input logic d, c);
        chk("strobe", strobe_out, {u, 1'b1, p, r, w, d, c});
    endtask

    task automatic pio(input logic [31:0] v);
        pio_normal_in = v;
        pio_write_in = 1'b1;
        @(negedge sys_clk_in);
        pio_write_in = 1'b0;
    endtask

    task automatic rst(input logic strap_n);
        srst_in = 1'b1;
        addr_enable_strap_n_in = strap_n;
        strap_pins_in = 16'($urandom);
        repeat (10) @(negedge sys_clk_in);
        srst_in = 1'b0;
        rd(1'b0, 20'h0fff6, strap_pins_in);
    endtask

    always @(negedge sys_clk_in) begin
        if (rdata_valid_out === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected read", 32'h1, 32'h0);
            end else begin
                chk("rdata", rdata_out, exp_q.pop_front());
            end
        end
    end

    initial begin
        #(CLK_PERIOD_NS * 2000);
        n_mismatch++;
        stop_test();
    end

    initial begin
        n_mismatch = 0;
        n_tests = 0;
        access_in = '0;
        mid_cfg_in = 3'h2;
        periph_low_cfg_in = 4'h0;
        periph_high_cfg_in = 4'h0;
        periph_addr_mode_in = 1'b0;
        pio_write_in = 1'b0;
        pio_normal_in = '0;
        void'($urandom(32'hc313f120));
        rst(1'b1);
        rd(1'b0, 20'h0fffe, RST_PERIPH_BLOCK_RELOC);
        rd(1'b0, 20'h0ffa0, RST_UPPER_SELECT_CONFIG);
        rd(1'b0, 20'h0ffa2, 16'h0000);
        rd(1'b0, 20'h0ff50, 16'h0000);
        st(1'b1, 1'b1, 1'b0, 4'h0, 1'b1, 1'b0);
        chk("fetch", fetch_addr_out, BOOT_FETCH_ADDR);
        chk("pio", pio_normal_out, RST_PIO_NORMAL);
        acc(1'b1, 1'b0, BOOT_FETCH_ADDR, 16'h0000);
        st(1'b0, 1'b0, 1'b1, 4'h3, 1'b1, 1'b0);
        acc(1'b1, 1'b0, 20'hef000, 16'h0000);
        st(1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 1'b0);
        acc(1'b0, 1'b1, 20'h0fff6, ~strap_pins_in);
        rd(1'b0, 20'h0fff6, strap_pins_in);
        acc(1'b0, 1'b1, 20'h0ffa0, 16'h6083);
        rd(1'b0, 20'h0ffa0, 16'h6083);
        acc(1'b1, 1'b0, 20'he1234, 16'h0000);
        st(1'b0, 1'b0, 1'b1, 4'h3, 1'b0, 1'b0);
        acc(1'b1, 1'b0, 20'hd1234, 16'h0000);
        st(1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 1'b0);
        acc(1'b0, 1'b1, 20'h0ffa2, 16'h0087);
        acc(1'b1, 1'b0, 20'h01234, 16'h0000);
        chk("low strobe", strobe_out, 10'h20c);
        acc(1'b1, 1'b0, 20'h80000, 16'h0000);
        st(1'b1, 1'b0, 1'b1, 4'h2, 1'b1, 1'b0);
        base = 16'($urandom & 32'h0000_0fff);
        acc(1'b0, 1'b1, 20'h0fffe, 16'hf000 | base);
        @(negedge sys_clk_in); // Outputs lag the register by one edge
        chk("slave", intc_slave_select_out, 1'b1);
        chk("space", block_space_select_out, 1'b1);
        rd(1'b1, {4'(32'h1 + $urandom % 7), base[7:0], 8'hfe}, 16'h5000 | base);
        st(1'b1, 1'b1, 1'b0, 4'h0, 1'b1, 1'b0);
        acc(1'b0, 1'b0, 20'h0fffe, 16'h0000);
        st(1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 1'b0);
        for (int c = 0; c < 8; c++) begin
            periph_low_cfg_in = {c[2], 1'b0, c[1:0]};
            acc(1'b0, 1'b0, 20'h01010, 16'h0000);
            st(1'b1, 1'b0, 1'b1, wtab[c], 1'b1, 1'b0);
        end
        periph_high_cfg_in = 4'h7;
        acc(1'b0, 1'b0, 20'h01100, 16'h0000);
        st(1'b1, 1'b0, 1'b0, 4'h3, 1'b1, 1'b0);
        periph_low_cfg_in = 4'h8;
        acc(1'b0, 1'b0, 20'h01110, 16'h0000);
        st(1'b1, 1'b0, 1'b1, 4'h5, 1'b1, 1'b1);
        periph_low_cfg_in = 4'h7;
        acc(1'b0, 1'b0, 20'h01110, 16'h0000);
        st(1'b1, 1'b0, 1'b0, 4'h3, 1'b1, 1'b0);
        periph_addr_mode_in = 1'b1;
        acc(1'b0, 1'b0, 20'h01600, 16'h0000);
        st(1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 1'b0);
        pio($urandom);
        chk("pio", pio_normal_out, pio_normal_in);
        rst(1'b0);
        chk("pio", pio_normal_out, RST_PIO_NORMAL);
        pio(32'h0000_0000);
        chk("pio", pio_normal_out, 32'h2400_0000);
        acc(1'b0, 1'b1, 20'h0ffa0, 16'hf0bb);
        acc(1'b1, 1'b0, 20'hf0000, 16'h0000);
        st(1'b0, 1'b0, 1'b1, 4'h3, 1'b1, 1'b0);
        chk("reads left", exp_q.size(), 32'h0);
        stop_test();
    end
endmodule // testbench
